// ---- logic/iopc_pkg.sv ----
// Package: constants and types for the I/O processor channel
//
// Overview of operation
// RULE1 - Serve up to eight subchannel break lines
// RULE2 - Channel number identifies one of eight processors
// RULE3 - Bus mastership priority follows daisy chain place
// RULE4 - Fixed priority encoder over eight break lines
// RULE5 - Pending break raises a bus cycle request
// RULE6 - One exchange with highest pending break
// RULE7 - Two 16-bit control words per subchannel
// RULE8 - Software loads control words before starting
// RULE9 - Winning index selects, reads, updates control words
// RULE10 - Act as slave for external register access
// RULE11 - Address from instruction bits, data from scratch
// RULE12 - Address holds channel and subchannel fields
// RULE13 - Exchange is two bus cycles, device master
// RULE14 - Control unit drops break once exchange starts
// RULE15 - Rebreak served next unless higher request pending
// RULE16 - Readiness by break line, unit stays addressable
// RULE17 - Several subchannels interleave by priority
// RULE18 - Condition code 0 accepted, 1 rejected, 3 unknown
// RULE19 - Up to 256 external registers, both directions
// RULE20 - Unit rebreaks only after returning to exchange
// RULE21 - Step address and count, flag block completion
`default_nettype none
package iopc_pkg;
  localparam int IOPC_SUBS    = 8;
  localparam int IOPC_CHANS   = 8;
  localparam int IOPC_WORD_W  = 16;
  localparam int IOPC_XREG_N  = 256;
  // External register address: [7:5] channel, [4:2] subchannel, [1] word select
  localparam int IOPC_CHAN_LSB = 5;
  localparam int IOPC_SUB_LSB  = 2;
  localparam int IOPC_WSEL_BIT = 1;
  // Wishbone byte offsets (word index in address bits [9:2])
  localparam logic [11:0] IOPC_XREG_BASE  = 12'h000;
  localparam logic [11:0] IOPC_CHAN_OFF   = 12'h400;
  localparam logic [11:0] IOPC_DONE_OFF   = 12'h404;
  localparam logic [11:0] IOPC_STAT_OFF   = 12'h408;
  localparam logic [11:0] IOPC_CC_OFF     = 12'h40C;
  // First control word: [15] direction (1 = memory to unit), [14:0] word address
  localparam int IOPC_DIR_BIT = 15;
  localparam logic [15:0] IOPC_CW_RESET   = 16'h0000;
  localparam logic [2:0]  IOPC_CHAN_RESET = 3'h0;
  // Condition codes
  localparam logic [1:0] IOPC_CC_ACCEPT  = 2'h0;
  localparam logic [1:0] IOPC_CC_REJECT  = 2'h1;
  localparam logic [1:0] IOPC_CC_UNKNOWN = 2'h3;

  typedef enum logic [2:0] {
    IOPC_IDLE   = 3'b000,
    IOPC_REQ    = 3'b001,
    IOPC_CYC1   = 3'b010,
    IOPC_CYC2   = 3'b011,
    IOPC_UPDATE = 3'b100
  } iopc_state_t;

  function automatic logic [7:0] iopc_xaddr(input logic [2:0] chan, input logic [2:0] sub, input logic wsel);
    iopc_xaddr = {chan, sub, wsel, 1'b0};
  endfunction
endpackage : iopc_pkg
`default_nettype wire

// ---- logic/iopc_prio_enc.sv ----
// Fixed priority encoder over the subchannel break lines
`default_nettype none
module iopc_prio_enc
  import iopc_pkg::*;
(
  // Requests
  input  wire logic [7:0] req_i,
  // Result
  output logic            any_o,
  output logic [2:0]      idx_o
);
  // Line 0 has the highest priority
  always_comb begin
    any_o = |req_i;
    idx_o = 3'h0;
    for (int i = IOPC_SUBS - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = 3'(i); // [RULE4]
      end
    end
  end
endmodule // iopc_prio_enc
`default_nettype wire

// ---- logic/iopc_cw_ram.sv ----
// Control word store: two words per subchannel, two ports
`default_nettype none
module iopc_cw_ram
  import iopc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Port A: software
  input  wire logic [3:0]  a_addr_i,
  input  wire logic        a_we_i,
  input  wire logic [15:0] a_wdata_i,
  output logic [15:0]      a_rdata_o,
  // Port B: exchange engine
  input  wire logic [2:0]  b_sub_i,
  input  wire logic        b_we_i,
  input  wire logic [15:0] b_cw1_i,
  input  wire logic [15:0] b_cw2_i,
  output logic [15:0]      b_cw1_o,
  output logic [15:0]      b_cw2_o
);
  logic [15:0] mem [16];
  logic [15:0] next_mem [16];

  always_comb begin
    next_mem = mem;
    if (b_we_i) begin
      next_mem[{b_sub_i, 1'b0}] = b_cw1_i; // [RULE9]
      next_mem[{b_sub_i, 1'b1}] = b_cw2_i;
    end
    // Software write wins over engine update of the same word
    if (a_we_i) begin
      next_mem[a_addr_i] = a_wdata_i; // [RULE7]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= IOPC_CW_RESET;
      end
    end else begin
      mem <= next_mem;
    end
  end

  assign a_rdata_o = mem[a_addr_i];
  assign b_cw1_o   = mem[{b_sub_i, 1'b0}];
  assign b_cw2_o   = mem[{b_sub_i, 1'b1}];
endmodule // iopc_cw_ram
`default_nettype wire

// ---- logic/iopc_channel.sv ----
// I/O processor channel: break arbitration, exchange engine, register slave
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none
module iopc_channel
  import iopc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Subchannel break lines (asynchronous)
  input  wire logic [7:0]  brk_i,
  // Bus mastership daisy chain
  input  wire logic        grant_in_i,
  output logic             grant_out_o,
  output logic             bus_req_o,
  // Exchange bus as master
  output logic             xbus_cyc_o,
  output logic             xbus_mem_o,
  output logic             xbus_wr_o,
  output logic [14:0]      xbus_adr_o,
  output logic [2:0]       xbus_sub_o,
  input  wire logic        xbus_ack_i,
  // Block completion
  output logic [7:0]       done_o
);
  // A request is taken on the edge that sees it with ack low
  function automatic logic wb_take(input logic cyc, input logic stb, input logic acked);
    wb_take = cyc && stb && !acked;
  endfunction

  // Memory is written when the unit is the source
  function automatic logic mem_writes(input logic [15:0] cw);
    mem_writes = !cw[IOPC_DIR_BIT];
  endfunction

  // Break synchroniser
  logic [7:0] brk_s1, brk_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_s1 <= 8'h00;
      brk_s2 <= 8'h00;
    end else begin
      brk_s1 <= brk_i;
      brk_s2 <= brk_s1;
    end
  end

  // Grant synchroniser
  logic gnt_s1, gnt_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gnt_s1 <= 1'b0;
      gnt_s2 <= 1'b0;
    end else begin
      gnt_s1 <= grant_in_i;
      gnt_s2 <= gnt_s1;
    end
  end

  logic       brk_any;
  logic [2:0] brk_idx;
  iopc_prio_enc u_enc (
    .req_i (brk_s2),
    .any_o (brk_any),
    .idx_o (brk_idx)
  ); // [RULE1] [RULE4] [RULE16]

  // Register state
  logic [2:0]  chan_id, next_chan_id;
  logic [7:0]  done, next_done;
  logic [1:0]  cc, next_cc;
  logic        ack, next_ack;
  logic [31:0] rdat, next_rdat;

  // Engine state
  iopc_state_t st, next_st;
  logic [2:0]  sub, next_sub;
  logic [15:0] cw1, next_cw1;
  logic [15:0] cw2, next_cw2;
  logic        req, next_req;
  logic        gout, next_gout;
  logic        xcyc, next_xcyc;
  logic        xmem, next_xmem;
  logic        xwr, next_xwr;
  logic [14:0] xadr, next_xadr;

  // Control word store wiring
  logic [15:0] a_rdata, b_cw1, b_cw2;
  logic        a_we, b_we;
  logic [2:0]  b_sel;
  logic [3:0]  a_addr;
  logic        xreg_hit, xreg_own;
  logic [7:0]  xa;

  assign xa       = wb_adr_i[9:2];
  assign xreg_hit = wb_adr_i[11:10] == IOPC_XREG_BASE[11:10];
  assign xreg_own = xa[7:IOPC_CHAN_LSB] == chan_id; // [RULE2] [RULE12]
  assign a_addr   = {xa[IOPC_SUB_LSB +: 3], xa[IOPC_WSEL_BIT]};
  assign a_we     = wb_take(wb_cyc_i, wb_stb_i, ack) && wb_we_i && xreg_hit && xreg_own && (&wb_sel_i[1:0]);
  assign b_we     = st == IOPC_UPDATE;
  // The winner's words are read while asking, the served ones are written back
  assign b_sel    = (st == IOPC_REQ) ? brk_idx : sub; // [RULE9]

  iopc_cw_ram u_ram (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .a_addr_i  (a_addr),
    .a_we_i    (a_we),
    .a_wdata_i (wb_dat_i[15:0]),
    .a_rdata_o (a_rdata),
    .b_sub_i   (b_sel),
    .b_we_i    (b_we),
    .b_cw1_i   (cw1),
    .b_cw2_i   (cw2),
    .b_cw1_o   (b_cw1),
    .b_cw2_o   (b_cw2)
  );

  // Wishbone slave, answers one cycle after the request
  always_comb begin
    next_ack     = 1'b0;
    next_rdat    = 32'h0000_0000;
    next_chan_id = chan_id;
    next_cc      = cc;
    next_done    = done;
    if (wb_take(wb_cyc_i, wb_stb_i, ack)) begin
      next_ack = 1'b1;
      // Own control words answer, other channels are unknown
      if (xreg_hit) begin // [RULE10] [RULE19]
        if (xreg_own) begin
          // A control word is written whole or not at all
          if (wb_we_i && !(&wb_sel_i[1:0])) begin
            next_cc = IOPC_CC_REJECT; // [RULE18]
          end else begin
            next_cc = IOPC_CC_ACCEPT; // [RULE18]
          end
          if (!wb_we_i) begin
            next_rdat = {16'h0000, a_rdata};
          end
        end else begin
          next_cc = IOPC_CC_UNKNOWN;
        end
      end else begin
        case (wb_adr_i)
          IOPC_CHAN_OFF: begin
            if (wb_we_i && wb_sel_i[0]) begin
              next_chan_id = wb_dat_i[2:0];
            end
            next_rdat = {29'h0, chan_id};
          end
          IOPC_DONE_OFF: begin
            next_rdat = {24'h0, done};
          end
          IOPC_STAT_OFF: begin
            next_rdat = {24'h0, brk_s2};
          end
          IOPC_CC_OFF: begin
            next_rdat = {30'h0, cc};
          end
          default: begin
            next_rdat = 32'h0000_0000;
          end
        endcase
      end
    end
    // Completion flags: write one to clear, a new completion wins
    if (wb_take(wb_cyc_i, wb_stb_i, ack) && wb_we_i && wb_adr_i == IOPC_DONE_OFF && wb_sel_i[0]) begin
      next_done = done & ~wb_dat_i[7:0];
    end
    if (b_we && cw2 == 16'h0000) begin
      next_done[sub] = 1'b1; // [RULE21]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack     <= 1'b0;
      rdat    <= 32'h0000_0000;
      chan_id <= IOPC_CHAN_RESET;
      cc      <= IOPC_CC_ACCEPT;
      done    <= 8'h00;
    end else begin
      ack     <= next_ack;
      rdat    <= next_rdat;
      chan_id <= next_chan_id;
      cc      <= next_cc;
      done    <= next_done;
    end
  end

  // Exchange engine
  always_comb begin
    next_st   = st;
    next_sub  = sub;
    next_cw1  = cw1;
    next_cw2  = cw2;
    next_req  = req;
    next_gout = 1'b0;
    next_xcyc = 1'b0;
    next_xmem = xmem;
    next_xwr  = xwr;
    next_xadr = xadr;
    case (st)
      IOPC_IDLE: begin
        // Pass the grant down when not asking, and keep a passed grant whole
        // A grant still up from an earlier exchange is not taken again
        next_gout = gnt_s2 && (gout || !brk_any); // [RULE3]
        if (brk_any && !gnt_s2) begin
          next_req = 1'b1; // [RULE5]
          next_st  = IOPC_REQ;
        end
      end
      IOPC_REQ: begin
        // Control words come from the winning subchannel
        if (gnt_s2) begin
          next_sub  = brk_idx; // [RULE6] [RULE17]
          next_cw1  = b_cw1;
          next_cw2  = b_cw2;
          next_xcyc = 1'b1;
          next_xmem = 1'b1;
          next_xwr  = mem_writes(b_cw1);
          next_xadr = b_cw1[14:0];
          next_st   = IOPC_CYC1; // [RULE13]
        end
      end
      IOPC_CYC1: begin
        next_xcyc = 1'b1;
        if (xbus_ack_i) begin
          next_xcyc = 1'b0;
          next_xmem = 1'b0;
          next_xwr  = !mem_writes(cw1);
          next_st   = IOPC_CYC2;
        end
      end
      IOPC_CYC2: begin
        next_xcyc = 1'b1;
        // Step address and count once the unit cycle is answered
        if (xbus_ack_i && xcyc) begin
          next_xcyc = 1'b0;
          next_cw1  = {cw1[15], 15'(cw1[14:0] + 15'h1)}; // [RULE21]
          next_cw2  = (cw2 == 16'h0000) ? cw2 : 16'(cw2 - 16'h1);
          next_st   = IOPC_UPDATE;
        end
      end
      IOPC_UPDATE: begin
        // A fresh break is served straight away, else release the bus
        next_req = brk_any; // [RULE15] [RULE14] [RULE20]
        next_st  = brk_any ? IOPC_REQ : IOPC_IDLE;
      end
      default: begin
        next_st  = IOPC_IDLE;
        next_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st   <= IOPC_IDLE;
      sub  <= 3'h0;
      cw1  <= IOPC_CW_RESET;
      cw2  <= IOPC_CW_RESET;
      req  <= 1'b0;
      gout <= 1'b0;
      xcyc <= 1'b0;
      xmem <= 1'b0;
      xwr  <= 1'b0;
      xadr <= 15'h0000;
    end else begin
      st   <= next_st;
      sub  <= next_sub;
      cw1  <= next_cw1;
      cw2  <= next_cw2;
      req  <= next_req;
      gout <= next_gout;
      xcyc <= next_xcyc;
      xmem <= next_xmem;
      xwr  <= next_xwr;
      xadr <= next_xadr;
    end
  end

  assign wb_dat_o    = rdat;
  assign wb_ack_o    = ack;
  assign bus_req_o   = req;
  assign grant_out_o = gout;
  assign xbus_cyc_o  = xcyc;
  assign xbus_mem_o  = xmem;
  assign xbus_wr_o   = xwr;
  assign xbus_adr_o  = xadr;
  assign xbus_sub_o  = sub;
  assign done_o      = done;
endmodule // iopc_channel
`default_nettype wire

// ---- dv/iopc_channel_properties.sv ----
// Port checker for the I/O processor channel
`default_nettype none
module iopc_channel_chk
  import iopc_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Breaks, chain and exchange bus
  input wire logic [7:0]  brk_i,
  input wire logic        grant_out_o,
  input wire logic        bus_req_o,
  input wire logic        xbus_cyc_o,
  input wire logic        xbus_mem_o,
  input wire logic        xbus_wr_o,
  input wire logic [14:0] xbus_adr_o,
  input wire logic        xbus_ack_i,
  input wire logic [7:0]  done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_mem_done; xbus_cyc_o && xbus_mem_o && xbus_ack_i; endsequence
  sequence s_unit_cyc; xbus_cyc_o && !xbus_mem_o; endsequence
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  a_req_pending: assert property ((brk_i != 8'h00 && $stable(brk_i)) [*4] |-> ##[0:3] (bus_req_o || xbus_cyc_o))
    else $error("pending break without bus request");
  a_cyc_after_req: assert property ($rose(xbus_cyc_o) && xbus_mem_o |-> $past(bus_req_o))
    else $error("exchange without request");
  a_cyc_hold: assert property (xbus_cyc_o && !xbus_ack_i |=> xbus_cyc_o && $stable(xbus_adr_o) && $stable(xbus_mem_o))
    else $error("exchange cycle changed before ack");
  a_two_cycles: assert property (s_mem_done |-> ##[1:3] s_unit_cyc)
    else $error("unit cycle missing after memory cycle");
  a_wr_flip: assert property (s_mem_done |=> xbus_wr_o != $past(xbus_wr_o))
    else $error("unit cycle direction not opposite to memory cycle");
  a_grant_pass: assert property (grant_out_o |-> !bus_req_o && !xbus_cyc_o)
    else $error("grant passed while busy");
  a_done_clear: assert property ((($past(done_o) & ~done_o) != 8'h00)
    |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == IOPC_DONE_OFF))
    else $error("done flag lost without clear");
endmodule // iopc_channel_chk
bind iopc_channel iopc_channel_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .brk_i(brk_i),
  .grant_out_o(grant_out_o), .bus_req_o(bus_req_o), .xbus_cyc_o(xbus_cyc_o), .xbus_mem_o(xbus_mem_o),
  .xbus_wr_o(xbus_wr_o), .xbus_adr_o(xbus_adr_o), .xbus_ack_i(xbus_ack_i), .done_o(done_o));
`default_nettype wire

// ---- dv/iopc_far_model.sv ----
// Far side model: control units, memory and the chain above
`default_nettype none
module iopc_far_model (
  // Clock, reset and bench control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] raise_i,
  input  wire logic       slow_i,
  // Channel side
  input  wire logic       bus_req_i,
  input  wire logic       xbus_cyc_i,
  input  wire logic       xbus_mem_i,
  input  wire logic [2:0] xbus_sub_i,
  output logic [7:0]      brk_o,
  output logic            grant_o,
  output logic            xbus_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_o      <= 8'h00;
      grant_o    <= 1'b0;
      xbus_ack_o <= 1'b0;
      wait_cnt   <= 2'h0;
    end else begin
      // Break drops once its exchange is under way
      brk_o      <= (brk_o & ~((xbus_cyc_i && xbus_mem_i) ? 8'h01 << xbus_sub_i : 8'h00)) | raise_i;
      grant_o    <= bus_req_i;
      xbus_ack_o <= xbus_cyc_i && !xbus_ack_o && (!slow_i || wait_cnt == 2'h3);
      wait_cnt   <= (xbus_cyc_i && !xbus_ack_o) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // iopc_far_model
`default_nettype wire

// ---- dv/iopc_channel_tb_top.sv ----
// Self-checking bench for the I/O processor channel
`default_nettype none
module iopc_channel_tb_top
  import iopc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, slow = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0]  wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0, wb_rd;
  logic [7:0]  brk, raise = 8'h00, done;
  logic        grant, bus_req, x_cyc, x_mem, x_ack, x_wr;
  logic [14:0] x_adr, base [8];
  logic [2:0]  x_sub, chan;
  logic [43:0] rq [$];
  logic [18:0] xq [$];
  int          err_total = 0, cmp_count = 0, cycles = 0, seed;
  always #50 clk = ~clk;
  iopc_channel DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .brk_i(brk),
    .grant_in_i(grant), .grant_out_o(), .bus_req_o(bus_req), .xbus_cyc_o(x_cyc), .xbus_mem_o(x_mem),
    .xbus_wr_o(x_wr), .xbus_adr_o(x_adr), .xbus_sub_o(x_sub), .xbus_ack_i(x_ack), .done_o(done));
  iopc_far_model u_far (.clk_i(clk), .rst_i(rst), .raise_i(raise), .slow_i(slow), .bus_req_i(bus_req),
    .xbus_cyc_i(x_cyc), .xbus_mem_i(x_mem), .xbus_sub_i(x_sub), .brk_o(brk), .grant_o(grant), .xbus_ack_o(x_ack));
  function automatic logic [11:0] xa(input logic [2:0] c, input int s, input logic w);
    xa = {2'b00, c, s[2:0], w, 3'b000};
  endfunction
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back({a, e});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [7:0] m);
    raise <= m;
    @(posedge clk);
    raise <= 8'h00;
  endtask
  task automatic drain();
    while (xq.size() != 0 || bus_req !== 1'b0 || x_cyc !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      cmp("read", rq[0][31:0], wb_rd);
      void'(rq.pop_front());
    end
    if (x_cyc === 1'b1 && x_mem === 1'b1 && x_ack === 1'b1) begin
      cmp("exchange", {13'h0, xq[0]}, {13'h0, x_wr, x_sub, x_adr});
      void'(xq.pop_front());
    end
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    seed = 35;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(IOPC_CHAN_OFF, 32'h0);
    rd(IOPC_DONE_OFF, 32'h0);
    rd(12'h800, 32'h0);
    chan = 3'($random(seed));
    wb(1'b1, IOPC_CHAN_OFF, {29'h0, chan});
    rd(IOPC_CHAN_OFF, {29'h0, chan});
    for (int i = 0; i < 8; i++) begin
      base[i] = {3'(i), 12'($random(seed))};
      wb(1'b1, xa(chan, i, 1'b0), {17'h0, base[i]});
      wb(1'b1, xa(chan, i, 1'b1), 32'h1);
    end
    wb(1'b1, xa(chan + 3'h1, 0, 1'b0), 32'h7FFF);
    rd(IOPC_CC_OFF, 32'h3);
    wb(1'b1, xa(chan, 1, 1'b0), {17'h0, base[1]});
    rd(IOPC_CC_OFF, 32'h0);
    wb_sel <= 4'hC;
    wb(1'b1, xa(chan, 2, 1'b0), 32'h7FFF);
    wb_sel <= 4'hF;
    rd(IOPC_CC_OFF, 32'h1);
    rd(xa(chan, 2, 1'b0), {17'h0, base[2]});
    rd(xa(chan, 0, 1'b0), {17'h0, base[0]});
    rd(xa(chan, 5, 1'b1), 32'h1);
    $display("test registers done");
    for (int i = 0; i < 8; i++) xq.push_back({1'b1, 3'(i), base[i]});
    pulse(8'hFF);
    drain();
    rd(IOPC_DONE_OFF, 32'hFF);
    wb(1'b1, IOPC_DONE_OFF, 32'hFF);
    rd(IOPC_DONE_OFF, 32'h0);
    wb(1'b1, xa(chan, 7, 1'b0), {16'h0, 1'b1, base[7] + 15'h1});
    xq.push_back({1'b1, 3'h0, base[0] + 15'h1});
    xq.push_back({1'b0, 3'h7, base[7] + 15'h1});
    slow <= 1'b1;
    pulse(8'h81);
    drain();
    rd(IOPC_DONE_OFF, 32'h81);
    rd(xa(chan, 7, 1'b0), {16'h0, 1'b1, base[7] + 15'h2});
    wb(1'b1, IOPC_DONE_OFF, 32'h1);
    rd(IOPC_DONE_OFF, 32'h80);
    $display("test exchanges done");
    conclude();
  end
endmodule // iopc_channel_tb_top
`default_nettype wire
